// ### core/serial_status_map.svh
// Register offsets, field positions and reset values of the serial status block
`ifndef SERIAL_STATUS_MAP_SVH
`define SERIAL_STATUS_MAP_SVH
`define RX_DATA_OFFSET 8'h00
`define TX_DATA_LOW_OFFSET 8'h02
`define SERIAL_STATUS_OFFSET 8'h04
`define CONTROL_OFFSET 8'h05
`define IRQ_STATUS_OFFSET 8'h06
`define IRQ_MASK_OFFSET 8'h07
`define SERIAL_STATUS_RESET 8'h20
`define RX_COMPLETE_BIT 7
`define TX_COMPLETE_BIT 6
`define TX_BUFFER_EMPTY_BIT 5
`define RX_START_BIT 4
`define SYNC_ERROR_BIT 3
`define BREAK_DETECTED_BIT 1
`define WAIT_FOR_BREAK_BIT 0
`define CTRL_RX_ENABLE_BIT 0
`define CTRL_TX_ENABLE_BIT 1
`define CTRL_START_DETECT_BIT 2
`define CTRL_AUTO_BAUD_BIT 3
`define CTRL_LIN_AUTO_BIT 4
`define CTRL_SPI_MASTER_BIT 5
`define SYNC_CHARACTER 8'h55
`define BIT_TIME_MIN 16'h0010
`define BIT_TIME_MAX 16'h8000
`endif

// ### core/serial_status_pkg.sv
// Types shared by the serial status block
package serial_status_pkg;
  typedef enum logic [1:0] {rx_idle, rx_sync, rx_data} rx_state_e;
  typedef enum logic [1:0] {tx_idle, tx_shift} tx_state_e;
endpackage

// ### core/serial_bit_shifter.sv
// Frame shifter: serialises one 8-bit data frame with start and stop bit
`timescale 1ns/100ps
module serial_bit_shifter (
  input wire logic clock,
  input wire logic rst,
  input wire logic bit_tick,
  input wire logic load,
  input wire logic [7:0] load_data,
  output logic busy,
  output logic done,
  output logic tx_line
);
  logic [9:0] frame;
  logic [3:0] count;

  // Shift one bit per tick, pulse done in the cycle the stop bit is driven out
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame <= 10'h3FF;
      count <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
      tx_line <= 1'b1;
    end else begin
      done <= 1'b0;
      if (load && !busy) begin
        frame <= {1'b1, load_data, 1'b0};
        count <= 4'hA;
        busy <= 1'b1;
      end else if (busy && bit_tick) begin
        tx_line <= frame[0];
        frame <= {1'b1, frame[9:1]};
        count <= count - 4'h1;
        if (count == 4'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ### core/serial_port_status_flags.sv
// Serial port status flags, data buffers, interrupt logic and register port
//
// Overview of operation
// - Receive-complete follows unread receive buffer data
// - Disabling receiver flushes buffer, clearing flag
// - Transmit-complete sets when frame done, buffer empty
// - Transmit-complete cleared by vector or write one
// - Buffer-empty high when transmit buffer empty
// - Buffer-empty reads set after reset
// - Writing transmit low byte clears buffer-empty
// - Receive-start sets on falling edge in standby, not as SPI master
// - Receive-start reads zero unless detection enabled
// - Receive-start cleared only by writing one
// - Auto-baud bad bit time sets sync error
// - Auto LIN sync not 0x55 sets error
// - Writing one clears error, receiver goes idle
// - Interrupt request while latched interrupt status bit and enable set
`timescale 1ns/100ps
`include "serial_status_map.svh"
module serial_port_status_flags (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  input wire logic rx_line,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic [15:0] sync_bit_time,
  input wire logic sync_bit_time_valid,
  input wire logic standby,
  input wire logic bit_tick,
  input wire logic tx_complete_vector_ack,
  output logic tx_line,
  output logic irq
);
  logic rx_sync1, rx_sync2, rx_prev;
  logic [7:0] rx_data_register;
  logic [7:0] tx_data_register;
  logic rx_complete_flag, tx_complete_flag, tx_buffer_empty_flag;
  logic rx_start_flag, sync_field_error_flag;
  logic break_detected_flag, wait_for_break;
  logic [7:0] control;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic shifter_busy, shifter_done, shifter_line;
  logic load_shift;
  serial_status_pkg::rx_state_e rx_state;

  // Decode a write or read strobe to one register offset
  function automatic logic wr_hit(input logic [7:0] a, input logic s, input logic [7:0] off);
    return s && (a == off);
  endfunction

  logic wr_status, wr_tx, rd_rx, wr_ctrl, wr_irqs, wr_mask;
  assign wr_status = wr_hit(address, write_strobe, `SERIAL_STATUS_OFFSET);
  assign wr_tx = wr_hit(address, write_strobe, `TX_DATA_LOW_OFFSET);
  assign rd_rx = wr_hit(address, read_strobe, `RX_DATA_OFFSET);
  assign wr_ctrl = wr_hit(address, write_strobe, `CONTROL_OFFSET);
  assign wr_irqs = wr_hit(address, write_strobe, `IRQ_STATUS_OFFSET);
  assign wr_mask = wr_hit(address, write_strobe, `IRQ_MASK_OFFSET);

  logic rx_en, tx_en, start_det_en, auto_baud, lin_auto_mode, spi_master;
  assign rx_en = control[`CTRL_RX_ENABLE_BIT];
  assign tx_en = control[`CTRL_TX_ENABLE_BIT];
  assign start_det_en = control[`CTRL_START_DETECT_BIT];
  assign auto_baud = control[`CTRL_AUTO_BAUD_BIT];
  assign lin_auto_mode = control[`CTRL_LIN_AUTO_BIT];
  assign spi_master = control[`CTRL_SPI_MASTER_BIT];

  // Write-one-to-clear strobes of the status register
  logic clr_tx_complete, clr_rx_start, clr_sync_error;
  assign clr_tx_complete = wr_status && write_data[`TX_COMPLETE_BIT];
  assign clr_rx_start = wr_status && write_data[`RX_START_BIT];
  assign clr_sync_error = wr_status && write_data[`SYNC_ERROR_BIT];

  // Receive line synchroniser and edge history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_sync1 <= rx_line;
      rx_sync2 <= rx_sync1;
      rx_prev <= rx_sync2;
    end
  end

  logic start_edge;
  assign start_edge = rx_prev && !rx_sync2;

  // Control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control <= 8'h00;
    end else if (wr_ctrl) begin
      control <= write_data;
    end
  end

  // Receive state: sync check in auto LIN mode, back to idle on error clear
  logic sync_bad_char, sync_bad_time;
  assign sync_bad_char = lin_auto_mode && rx_byte_valid && (rx_state == serial_status_pkg::rx_sync)
    && (rx_byte != `SYNC_CHARACTER);
  assign sync_bad_time = auto_baud && sync_bit_time_valid
    && ((sync_bit_time < `BIT_TIME_MIN) || (sync_bit_time > `BIT_TIME_MAX));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_state <= serial_status_pkg::rx_idle;
    end else if (clr_sync_error) begin
      rx_state <= serial_status_pkg::rx_idle;
    end else begin
      case (rx_state)
        serial_status_pkg::rx_idle: begin
          if (rx_en && lin_auto_mode && start_edge) begin
            rx_state <= serial_status_pkg::rx_sync;
          end
        end
        serial_status_pkg::rx_sync: begin
          if (rx_byte_valid) begin
            rx_state <= sync_bad_char ? serial_status_pkg::rx_sync : serial_status_pkg::rx_data;
          end
        end
        serial_status_pkg::rx_data: begin
          if (!rx_en || !lin_auto_mode) begin
            rx_state <= serial_status_pkg::rx_idle;
          end
        end
        default: rx_state <= serial_status_pkg::rx_idle;
      endcase
    end
  end

  // Receive buffer and receive-complete flag; flush starts with the disabling write
  logic rx_store;
  assign rx_store = rx_en && rx_byte_valid && (rx_state != serial_status_pkg::rx_sync);
  logic rx_flush;
  assign rx_flush = !rx_en || (wr_ctrl && !write_data[`CTRL_RX_ENABLE_BIT]);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_data_register <= 8'h00;
      rx_complete_flag <= 1'b0;
    end else if (rx_flush) begin
      rx_complete_flag <= 1'b0;
    end else if (rx_store) begin
      rx_data_register <= rx_byte;
      rx_complete_flag <= 1'b1;
    end else if (rd_rx) begin
      rx_complete_flag <= 1'b0;
    end
  end

  // Transmit buffer and buffer-empty flag
  assign load_shift = tx_en && !tx_buffer_empty_flag && !shifter_busy;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_data_register <= 8'h00;
      tx_buffer_empty_flag <= 1'b1;
    end else if (wr_tx) begin
      tx_data_register <= write_data;
      tx_buffer_empty_flag <= 1'b0;
    end else if (load_shift) begin
      tx_buffer_empty_flag <= 1'b1;
    end
  end

  serial_bit_shifter shifter (
    .clock(clock),
    .rst(rst),
    .bit_tick(bit_tick),
    .load(load_shift),
    .load_data(tx_data_register),
    .busy(shifter_busy),
    .done(shifter_done),
    .tx_line(shifter_line)
  );

  // Transmit-complete flag; a set beats a clear in the same cycle
  logic frame_finished;
  assign frame_finished = shifter_done && tx_buffer_empty_flag && !wr_tx;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_complete_flag <= 1'b0;
    end else if (frame_finished) begin
      tx_complete_flag <= 1'b1;
    end else if (tx_complete_vector_ack || clr_tx_complete) begin
      tx_complete_flag <= 1'b0;
    end
  end

  // Receive-start flag: cleared only by writing one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_start_flag <= 1'b0;
    end else if (standby && start_det_en && !spi_master && start_edge) begin
      rx_start_flag <= 1'b1;
    end else if (clr_rx_start) begin
      rx_start_flag <= 1'b0;
    end
  end

  // Sync-field error flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_field_error_flag <= 1'b0;
    end else if (sync_bad_char || sync_bad_time) begin
      sync_field_error_flag <= 1'b1;
    end else if (clr_sync_error) begin
      sync_field_error_flag <= 1'b0;
    end
  end

  // Plain storage bits 1 and 0
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      break_detected_flag <= 1'b0;
      wait_for_break <= 1'b0;
    end else if (wr_status) begin
      break_detected_flag <= write_data[`BREAK_DETECTED_BIT];
      wait_for_break <= write_data[`WAIT_FOR_BREAK_BIT];
    end
  end

  // Status view; bit 2 reads zero
  logic [7:0] status_view;
  assign status_view = {rx_complete_flag, tx_complete_flag, tx_buffer_empty_flag,
    rx_start_flag && start_det_en, sync_field_error_flag, 1'b0,
    break_detected_flag, wait_for_break};

  // Sticky interrupt status, cleared by writing one; set wins
  logic [7:0] irq_events;
  logic [7:0] next_irq_status;
  assign irq_events = status_view;
  for (genvar b = 0; b < 8; b++) begin : g_irq_bit
    assign next_irq_status[b] = irq_events[b] || (irq_status[b] && !(wr_irqs && write_data[b]));
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= 8'h00;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Interrupt mask
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_mask <= 8'h00;
    end else if (wr_mask) begin
      irq_mask <= write_data;
    end
  end

  // Interrupt output held while a masked-in interrupt status bit stays set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Transmit line output register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_line <= 1'b1;
    end else begin
      tx_line <= shifter_line;
    end
  end

  // Register read mux, zero when no read is asked for
  logic [7:0] next_read_data;
  always_comb begin
    next_read_data = 8'h00;
    if (read_strobe) begin
      case (address)
        `RX_DATA_OFFSET: next_read_data = rx_data_register;
        `TX_DATA_LOW_OFFSET: next_read_data = tx_data_register;
        `SERIAL_STATUS_OFFSET: next_read_data = status_view;
        `CONTROL_OFFSET: next_read_data = control;
        `IRQ_STATUS_OFFSET: next_read_data = irq_status;
        `IRQ_MASK_OFFSET: next_read_data = irq_mask;
        default: next_read_data = 8'h00;
      endcase
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      read_data <= 8'h00;
    end else begin
      read_data <= next_read_data;
    end
  end
endmodule

// ### verification/serial_peer_model.sv
// Remote serial transceiver model driving the receive side of the block
`timescale 1ns/100ps
module serial_peer_model (
  input wire logic clock,
  output logic rx_line,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic [15:0] sync_bit_time,
  output logic sync_bit_time_valid
);
  // Idle line high, no character pending
  initial begin
    rx_line = 1'b1;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    sync_bit_time = 16'h0000;
    sync_bit_time_valid = 1'b0;
  end
  // Start bit: idle to low, then back to idle
  task automatic start_edge();
    @(posedge clock);
    rx_line <= 1'b0;
    repeat (4) @(posedge clock);
    rx_line <= 1'b1;
  endtask
  // One received character; data scrambled once released
  task automatic send_byte(input logic [7:0] b);
    @(posedge clock);
    rx_byte <= b;
    rx_byte_valid <= 1'b1;
    @(posedge clock);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~b;
  endtask
  // One measured sync bit time
  task automatic send_sync(input logic [15:0] t);
    @(posedge clock);
    sync_bit_time <= t;
    sync_bit_time_valid <= 1'b1;
    @(posedge clock);
    sync_bit_time_valid <= 1'b0;
    sync_bit_time <= ~t;
  endtask
endmodule

// ### verification/serial_port_status_flags_properties.sv
// Port-level checks of the serial status flag block
`timescale 1ns/100ps
module serial_port_status_flags_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [7:0] read_data,
  input wire logic rx_byte_valid,
  input wire logic bit_tick,
  input wire logic tx_complete_vector_ack,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Status register read
  sequence s_rd;
    read_strobe && address == 8'h04;
  endsequence
  property p_rst_val;
    $past(rst, 2) && read_strobe && address == 8'h04 |=> read_data == 8'h20;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad status after reset");
  property p_bit2;
    s_rd |=> !read_data[2];
  endproperty
  a_bit2: assert property (p_bit2) else $error("status bit 2 not zero");
  property p_rx_read;
    read_strobe && address == 8'h00 && !rx_byte_valid ##1 s_rd |=> !read_data[7];
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("rx flag kept after read");
  property p_rx_off;
    write_strobe && address == 8'h05 && !write_data[0] ##1 s_rd |=> !read_data[7];
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx flag kept when disabled");
  property p_start_off;
    write_strobe && address == 8'h05 && !write_data[2] ##1 s_rd |=> !read_data[4];
  endproperty
  a_start_off: assert property (p_start_off) else $error("start flag seen");
  property p_tx_write;
    write_strobe && address == 8'h02 ##1 s_rd |=> !read_data[5];
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("empty flag not cleared");
  property p_vec_clr;
    (!bit_tick)[*3] ##0 tx_complete_vector_ack ##1 s_rd |=> !read_data[6];
  endproperty
  a_vec_clr: assert property (p_vec_clr) else $error("tx flag kept after vector");
  property p_mask_off;
    write_strobe && address == 8'h07 && write_data == 8'h00 |-> ##2 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
  c_tx_done: cover property (s_rd ##1 read_data[6]);
  c_vec: cover property (tx_complete_vector_ack);
  c_irq: cover property ($rose(irq));
endmodule
bind serial_port_status_flags serial_port_status_flags_properties u_props (.clock, .rst,
  .address, .write_data, .write_strobe, .read_strobe, .read_data, .rx_byte_valid,
  .bit_tick, .tx_complete_vector_ack, .irq);

// ### verification/test_serial_port_status_flags.sv
// Self-checking bench for the serial status flag block
`timescale 1ns/100ps
module test_serial_port_status_flags;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic [7:0] write_data = 8'h00;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic standby = 1'b0;
  logic bit_tick = 1'b0;
  logic tick_on = 1'b1;
  logic [1:0] tick_count = 2'h0;
  logic ack = 1'b0;
  logic low_seen = 1'b0;
  logic [7:0] read_data, rx_byte, v;
  logic rx_line, rx_byte_valid, sync_bit_time_valid, tx_line, irq;
  logic [15:0] sync_bit_time;
  logic [15:0] times [4] = '{16'h000F, 16'h0010, 16'h8000, 16'h8001};
  logic [7:0] sync_exp [4] = '{8'h28, 8'h20, 8'h20, 8'h28};
  int failures = 0;
  int checked = 0;
  serial_peer_model u_peer (.clock, .rx_line, .rx_byte_valid, .rx_byte, .sync_bit_time,
    .sync_bit_time_valid);
  serial_port_status_flags u_dut (.clock, .rst, .address, .write_data, .write_strobe,
    .read_strobe, .read_data, .rx_line, .rx_byte_valid, .rx_byte, .sync_bit_time,
    .sync_bit_time_valid, .standby, .bit_tick, .tx_complete_vector_ack(ack), .tx_line, .irq);
  // Clock and baud tick
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    tick_count <= tick_count + 2'h1;
    bit_tick <= tick_on && tick_count == 2'h3;
    if (tx_line === 1'b0) low_seen <= 1'b1;
  end
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 v = read_data;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(v, exp);
  endtask
  // Write or read, then a status read with no gap
  task automatic bb(input logic w, input logic [7:0] a1, d1, exp);
    @(posedge clock);
    address <= a1;
    write_data <= d1;
    write_strobe <= w;
    read_strobe <= !w;
    @(posedge clock);
    address <= 8'h04;
    write_strobe <= 1'b0;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 chk(read_data, exp);
  endtask
  task automatic wait_tx();
    int n;
    n = 0;
    v = 8'h00;
    while (v[6] !== 1'b1 && n < 200) begin
      rd(8'h04);
      n++;
    end
    if (v[6] !== 1'b1) begin
      failures++;
      final_report();
    end
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clock);
    #1 chk({7'h00, irq}, {7'h00, e});
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rc(8'h04, 8'h20);
    rc(8'h01, 8'h00);
    wr(8'h04, 8'hDF);
    rc(8'h04, 8'h23);
    wr(8'h04, 8'h00);
    rc(8'h04, 8'h20);
    $display("test registers done");
    wr(8'h05, 8'h01);
    u_peer.send_byte(8'hA5);
    rc(8'h04, 8'hA0);
    rc(8'h00, 8'hA5);
    rc(8'h04, 8'h20);
    u_peer.send_byte(8'h5A);
    bb(1'b0, 8'h00, 8'h00, 8'h20);
    u_peer.send_byte(8'h3C);
    bb(1'b1, 8'h05, 8'h00, 8'h20);
    $display("test receive done");
    wr(8'h05, 8'h05);
    standby <= 1'b1;
    u_peer.start_edge();
    rc(8'h04, 8'h30);
    wr(8'h04, 8'h00);
    rc(8'h04, 8'h30);
    bb(1'b1, 8'h05, 8'h01, 8'h20);
    wr(8'h05, 8'h05);
    rc(8'h04, 8'h30);
    wr(8'h04, 8'h10);
    rc(8'h04, 8'h20);
    wr(8'h05, 8'h25);
    u_peer.start_edge();
    rc(8'h04, 8'h20);
    standby <= 1'b0;
    wr(8'h05, 8'h05);
    u_peer.start_edge();
    rc(8'h04, 8'h20);
    $display("test start detect done");
    wr(8'h05, 8'h02);
    bb(1'b1, 8'h02, 8'h3C, 8'h00);
    rc(8'h04, 8'h20);
    wait_tx();
    chk({7'h00, low_seen}, 8'h01);
    chk(v, 8'h60);
    wr(8'h07, 8'h40);
    irq_is(1'b1);
    wr(8'h07, 8'h00);
    irq_is(1'b0);
    tick_on <= 1'b0;
    repeat (3) @(posedge clock);
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    address <= 8'h04;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 chk(read_data, 8'h20);
    wr(8'h06, 8'h40);
    wr(8'h07, 8'h40);
    irq_is(1'b0);
    tick_on <= 1'b1;
    wr(8'h02, 8'h81);
    wait_tx();
    irq_is(1'b1);
    wr(8'h04, 8'h40);
    rc(8'h04, 8'h20);
    wr(8'h06, 8'h40);
    irq_is(1'b0);
    wr(8'h07, 8'h20);
    irq_is(1'b1);
    wr(8'h07, 8'h00);
    irq_is(1'b0);
    $display("test transmit done");
    wr(8'h05, 8'h09);
    for (int i = 0; i < 4; i++) begin
      u_peer.send_sync(times[i]);
      rc(8'h04, sync_exp[i]);
      wr(8'h04, 8'h08);
      rc(8'h04, 8'h20);
    end
    wr(8'h05, 8'h11);
    for (int i = 0; i < 2; i++) begin
      u_peer.start_edge();
      u_peer.send_byte(8'h54 + i[7:0]);
      rc(8'h04, i ? 8'h20 : 8'h28);
      wr(8'h04, 8'h08);
      rc(8'h04, 8'h20);
    end
    $display("test sync field done");
    final_report();
  end
endmodule
